// ==== core/pfm_pkg.sv ====
// Constants, types and helper functions of the pin function multiplexer
`default_nettype none

package pfm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Pin counts and register file shape
	localparam int PFM_PA_PINS = 14;
	localparam int PFM_PB_PINS = 16;
	localparam int PFM_FUNCS   = 4;
	localparam int PFM_NREGS   = 5;
	localparam int PFM_REG_W   = 16;

	// Register numbers inside the register file
	localparam int PFM_R_PA_FUNC  = 0;
	localparam int PFM_R_PA_DIR   = 1;
	localparam int PFM_R_PB_FUNC  = 2;
	localparam int PFM_R_PB_DIR   = 3;
	localparam int PFM_R_PB_FUNC2 = 4;

	// Printed offsets are register indices; byte address is four times
	localparam logic [31:0] PFM_IDX_PA_FUNC  = 32'hFFFFFC80;
	localparam logic [31:0] PFM_IDX_PA_DIR   = 32'hFFFFFC82;
	localparam logic [31:0] PFM_IDX_PB_FUNC  = 32'hFFFFFC88;
	localparam logic [31:0] PFM_IDX_PB_DIR   = 32'hFFFFFC8A;
	localparam logic [31:0] PFM_IDX_PB_FUNC2 = 32'hFFFFFC8E;
	localparam logic [PFM_NREGS-1:0][31:0] PFM_IDX = {
		PFM_IDX_PB_FUNC2, PFM_IDX_PB_DIR, PFM_IDX_PB_FUNC,
		PFM_IDX_PA_DIR, PFM_IDX_PA_FUNC};

	// Reset value and writable bits of each register
	localparam logic [15:0] PFM_RST_VAL      = 16'h0000;
	localparam logic [15:0] PFM_MASK_PA_FUNC = 16'h3FFF;
	localparam logic [15:0] PFM_MASK_PA_DIR  = 16'h3FF7;
	localparam logic [15:0] PFM_MASK_PB      = 16'hFFFF;
	localparam logic [PFM_NREGS-1:0][15:0] PFM_MASK = {
		PFM_MASK_PB, PFM_MASK_PB, PFM_MASK_PB,
		PFM_MASK_PA_DIR, PFM_MASK_PA_FUNC};

	// Port B: second register holds pins 0..7, first holds pins 8..15
	localparam int PFM_PB_PINS_PER_REG = 8;
	localparam int PFM_CODE_W          = 2;

	// Port A pins whose general port is function 2, and pins with none
	localparam logic [13:0] PFM_PA_GP_FN2 = 14'h0080;
	localparam logic [13:0] PFM_PA_NO_GP  = 14'h0008;

	// AHB encodings
	localparam logic [2:0] PFM_SIZE_BYTE = 3'h0;
	localparam logic [2:0] PFM_SIZE_HALF = 3'h1;
	localparam logic [1:0] PFM_RESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		PFM_FN1 = 2'b00,
		PFM_FN2 = 2'b01,
		PFM_FN3 = 2'b10,
		PFM_FN4 = 2'b11
	} pfm_func_e;

	////////////////////////////////////////////////////////////////////////
	// Byte address of a register index
	function automatic logic [31:0] pfm_addr(input logic [31:0] idx);
		return {idx[29:0], 2'b00};
	endfunction : pfm_addr

	// Low two byte lanes touched by an access
	function automatic logic [1:0] pfm_lanes(input logic [2:0] size,
		input logic [1:0] a);
		if (size == PFM_SIZE_BYTE) begin
			return (a == 2'h0) ? 2'b01 : (a == 2'h1) ? 2'b10 : 2'b00;
		end else if (size == PFM_SIZE_HALF) begin
			return a[1] ? 2'b00 : 2'b11;
		end
		return 2'b11;
	endfunction : pfm_lanes

	// Lane merge of write data into a register
	function automatic logic [15:0] pfm_merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] lanes,
		input logic [15:0] mask);
		logic [15:0] m;
		m = {lanes[1] ? wd[15:8] : old[15:8], lanes[0] ? wd[7:0] : old[7:0]};
		return m & mask;
	endfunction : pfm_merge

endpackage : pfm_pkg

`default_nettype wire

// ==== core/pfm_pin_cell.sv ====
// One shared pin: output, enable and input routing by function code
`default_nettype none

module pfm_pin_cell #(
	parameter bit         HAS_GPIO = 1'b1,
	parameter logic [1:0] GP_CODE  = 2'b00
) (
	input  wire logic               hclk,     // Bus clock
	input  wire logic               hresetn,  // Power-on reset, low
	input  wire pfm_pkg::pfm_func_e code,     // Selected function
	input  wire logic               dir,      // General pin direction
	input  wire logic               pin_in,   // Level on the pin
	input  wire logic               gpio_out, // General port data
	input  wire logic [3:0]         fn_out,   // Peripheral outputs
	input  wire logic [3:0]         fn_oe,    // Peripheral enables
	output logic                    pin_out,  // Pin drive level
	output logic                    pin_oe,   // Pin drive enable
	output logic                    gpio_in,  // Pin level to port
	output logic [3:0]              fn_in     // Pin level to peripherals
);
	import pfm_pkg::*;

	wire       gp_sel = HAS_GPIO && (code == GP_CODE);
	wire       oe_next = gp_sel ? dir : fn_oe[code];
	wire       out_next = gp_sel ? gpio_out : fn_out[code];
	wire [3:0] onehot = 4'(4'h1 << code);
	wire [3:0] fn_in_next = gp_sel ? 4'h0 : (onehot & {4{pin_in}});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
			gpio_in <= 1'b0;
			fn_in   <= 4'h0;
		end else begin
			pin_out <= out_next;
			pin_oe  <= oe_next;
			gpio_in <= pin_in;
			fn_in   <= fn_in_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_gp_dir_oe: assert property (gp_sel |=> pin_oe == $past(dir))
		else $error("general pin enable does not follow direction");
	a_periph_oe: assert property (
		!gp_sel |=> pin_oe == $past(fn_oe[code])
		&& pin_out == $past(fn_out[code]))
		else $error("peripheral does not own the pin drive");
	a_input_route: assert property (
		##1 $onehot0(fn_in) && (fn_in == 4'h0 || !$past(gp_sel)))
		else $error("pin input routed to more than one owner");

endmodule : pfm_pin_cell

`default_nettype wire

// ==== core/pfm_mux.sv ====
// Pin function multiplexer top: AHB-Lite registers and pin cells
//
// The implementer's own choice: the AHB-Lite register port.
`default_nettype none

module pfm_mux (
	input  wire logic        hclk,       // Bus clock, 20 MHz
	input  wire logic        hresetn,    // Power-on reset, low
	input  wire logic        hsel,       // Slave select
	input  wire logic [31:0] haddr,      // Byte address
	input  wire logic [1:0]  htrans,     // Transfer type
	input  wire logic        hwrite,     // Write when high
	input  wire logic [2:0]  hsize,      // Access size
	input  wire logic [31:0] hwdata,     // Write data
	input  wire logic        hready,     // Bus ready
	output logic             hreadyout,  // Slave ready
	output logic [31:0]      hrdata,     // Read data
	output logic [1:0]       hresp,      // Response
	input  wire logic [pfm_pkg::PFM_PA_PINS-1:0] pa_pin_in,   // A levels
	output logic [pfm_pkg::PFM_PA_PINS-1:0]      pa_pin_out,  // A drive
	output logic [pfm_pkg::PFM_PA_PINS-1:0]      pa_pin_oe,   // A enable
	input  wire logic [pfm_pkg::PFM_PA_PINS-1:0] pa_gpio_out, // A port data
	output logic [pfm_pkg::PFM_PA_PINS-1:0]      pa_gpio_in,  // A to port
	input  wire logic [4*pfm_pkg::PFM_PA_PINS-1:0] pa_fn_out, // A periph out
	input  wire logic [4*pfm_pkg::PFM_PA_PINS-1:0] pa_fn_oe,  // A periph en
	output logic [4*pfm_pkg::PFM_PA_PINS-1:0]      pa_fn_in,  // A periph in
	input  wire logic [pfm_pkg::PFM_PB_PINS-1:0] pb_pin_in,   // B levels
	output logic [pfm_pkg::PFM_PB_PINS-1:0]      pb_pin_out,  // B drive
	output logic [pfm_pkg::PFM_PB_PINS-1:0]      pb_pin_oe,   // B enable
	input  wire logic [pfm_pkg::PFM_PB_PINS-1:0] pb_gpio_out, // B port data
	output logic [pfm_pkg::PFM_PB_PINS-1:0]      pb_gpio_in,  // B to port
	input  wire logic [4*pfm_pkg::PFM_PB_PINS-1:0] pb_fn_out, // B periph out
	input  wire logic [4*pfm_pkg::PFM_PB_PINS-1:0] pb_fn_oe,  // B periph en
	output logic [4*pfm_pkg::PFM_PB_PINS-1:0]      pb_fn_in   // B periph in
);
	import pfm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus address phase
	logic [15:0]          cfg_reg  [PFM_NREGS];
	logic [15:0]          cfg_next [PFM_NREGS];
	logic [PFM_NREGS-1:0] dp_sel_reg;
	logic                 dp_write_reg;
	logic [1:0]           dp_lanes_reg;
	logic [31:0]          hrdata_next;
	logic [15:0]          rd_word;
	logic                 first_cyc_reg;

	wire                 xfer = hsel && htrans[1] && hready;
	wire [1:0]           a_lanes = pfm_lanes(hsize, haddr[1:0]);
	wire [PFM_NREGS-1:0] a_sel;

	genvar r;
	generate
		for (r = 0; r < PFM_NREGS; r++) begin : g_reg
			// Match the word, so byte lanes of a register decode too
			wire [31:0] reg_addr = pfm_addr(PFM_IDX[r]);
			assign a_sel[r] = (haddr[31:2] == reg_addr[31:2]);
			// Writes land in the data phase, masked to the live bits
			assign cfg_next[r] = (dp_write_reg && dp_sel_reg[r])
				? pfm_merge(cfg_reg[r], hwdata[15:0], dp_lanes_reg,
					PFM_MASK[r])
				: cfg_reg[r];

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cfg_reg[r] <= PFM_RST_VAL;
				end else begin
					cfg_reg[r] <= cfg_next[r];
				end
			end
		end
	endgenerate

	// Read from next values so a read right after a write sees it
	always_comb begin
		rd_word = 16'h0000;
		for (int k = 0; k < PFM_NREGS; k++) begin
			if (a_sel[k]) begin
				rd_word = rd_word | cfg_next[k];
			end
		end
	end

	// Unmapped reads return zero; writes there are dropped
	assign hrdata_next = (xfer && !hwrite) ? {16'h0000, rd_word} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_sel_reg    <= '0;
			dp_write_reg  <= 1'b0;
			dp_lanes_reg  <= 2'b00;
			hrdata        <= 32'h0;
			hreadyout     <= 1'b1;
			hresp         <= PFM_RESP_OKAY;
			first_cyc_reg <= 1'b1;
		end else begin
			dp_sel_reg    <= xfer ? a_sel : '0;
			dp_write_reg  <= xfer && hwrite;
			dp_lanes_reg  <= a_lanes;
			hrdata        <= hrdata_next;
			hreadyout     <= 1'b1;
			hresp         <= PFM_RESP_OKAY;
			first_cyc_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Function codes, from registers only
	wire [31:0] pb_codes = {cfg_reg[PFM_R_PB_FUNC], cfg_reg[PFM_R_PB_FUNC2]};
	pfm_func_e  pa_code [PFM_PA_PINS];
	pfm_func_e  pb_code [PFM_PB_PINS];

	genvar i;
	generate
		for (i = 0; i < PFM_PA_PINS; i++) begin : g_pa
			// One mode bit per pin, high code bit always zero
			assign pa_code[i] =
				pfm_func_e'({1'b0, cfg_reg[PFM_R_PA_FUNC][i]});
			pfm_pin_cell #(
				.HAS_GPIO (!PFM_PA_NO_GP[i]),
				.GP_CODE  (PFM_PA_GP_FN2[i] ? PFM_FN2 : PFM_FN1)
			) u_cell (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.code     (pa_code[i]),
				.dir      (cfg_reg[PFM_R_PA_DIR][i]),
				.pin_in   (pa_pin_in[i]),
				.gpio_out (pa_gpio_out[i]),
				.fn_out   (pa_fn_out[4*i +: 4]),
				.fn_oe    (pa_fn_oe[4*i +: 4]),
				.pin_out  (pa_pin_out[i]),
				.pin_oe   (pa_pin_oe[i]),
				.gpio_in  (pa_gpio_in[i]),
				.fn_in    (pa_fn_in[4*i +: 4])
			);
		end
		for (i = 0; i < PFM_PB_PINS; i++) begin : g_pb
			assign pb_code[i] =
				pfm_func_e'(pb_codes[PFM_CODE_W*i +: PFM_CODE_W]);
			pfm_pin_cell #(
				.HAS_GPIO (1'b1),
				.GP_CODE  (PFM_FN1)
			) u_cell (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.code     (pb_code[i]),
				.dir      (cfg_reg[PFM_R_PB_DIR][i]),
				.pin_in   (pb_pin_in[i]),
				.gpio_out (pb_gpio_out[i]),
				.fn_out   (pb_fn_out[4*i +: 4]),
				.fn_oe    (pb_fn_oe[4*i +: 4]),
				.pin_out  (pb_pin_out[i]),
				.pin_oe   (pb_pin_oe[i]),
				.gpio_in  (pb_gpio_in[i]),
				.fn_in    (pb_fn_in[4*i +: 4])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_write_addr(int n);
		xfer && hwrite && a_sel[n] && a_lanes == 2'b11;
	endsequence

	sequence s_read_addr(int n);
		xfer && !hwrite && a_sel[n];
	endsequence

	a_reset_clear: assert property (first_cyc_reg |->
		cfg_reg[PFM_R_PA_FUNC] == 16'h0000 && cfg_reg[PFM_R_PB_FUNC] == 16'h0000
		&& cfg_reg[PFM_R_PB_FUNC2] == 16'h0000)
		else $error("function registers not cleared by reset");
	a_gpio_input: assert property (first_cyc_reg |->
		cfg_reg[PFM_R_PA_DIR] == 16'h0000 && cfg_reg[PFM_R_PB_DIR] == 16'h0000
		##1 (pb_pin_oe == '0))
		else $error("general pin drives after reset");
	a_word_write: assert property (s_write_addr(PFM_R_PB_DIR) ##1 1'b1 |=>
		cfg_reg[PFM_R_PB_DIR] == $past(hwdata[15:0]))
		else $error("port b direction write lost");
	a_byte_write: assert property (
		xfer && hwrite && a_sel[PFM_R_PB_FUNC] && hsize == PFM_SIZE_BYTE
		&& haddr[1:0] == 2'h1 ##1 1'b1 |=>
		cfg_reg[PFM_R_PB_FUNC][7:0] == $past(cfg_reg[PFM_R_PB_FUNC][7:0])
		&& cfg_reg[PFM_R_PB_FUNC][15:8] == $past(hwdata[15:8]))
		else $error("byte write touched the wrong lane");
	a_pa_upper_zero: assert property (
		cfg_reg[PFM_R_PA_FUNC][15:14] == 2'b00)
		else $error("reserved port a bits not zero");
	a_read_back: assert property (s_read_addr(PFM_R_PA_DIR) |=>
		hrdata == {16'h0000, $past(cfg_next[PFM_R_PA_DIR])}
		&& hrdata[3] == 1'b0)
		else $error("port a direction readback wrong");
	a_pb_code_map: assert property (
		pb_code[9] == pfm_func_e'(cfg_reg[PFM_R_PB_FUNC][3:2])
		&& pb_code[0] == pfm_func_e'(cfg_reg[PFM_R_PB_FUNC2][1:0]))
		else $error("port b code taken from wrong bits");
	a_code_hold: assert property (
		!dp_write_reg |=> $stable(pb_codes) && $stable(pa_code[0]))
		else $error("pin function changed without a write");
	a_bus_okay: assert property (hreadyout && hresp == PFM_RESP_OKAY)
		else $error("slave stalled or returned an error");
	a_pa_gp_oe: assert property (
		cfg_reg[PFM_R_PA_FUNC][5] == 1'b0 ##1 cfg_reg[PFM_R_PA_FUNC][5] == 1'b0
		|-> pa_pin_oe[5] == $past(cfg_reg[PFM_R_PA_DIR][5]))
		else $error("general port a pin ignores direction");

endmodule : pfm_mux

`default_nettype wire

// ==== testbench/pfm_pin_model.sv ====
// Pin level model: driven pins echo their drive, released pins toggle
`default_nettype none

module pfm_pin_model #(
	parameter int N = 14
) (
	input  wire logic [N-1:0] pin_out, // Drive level
	input  wire logic [N-1:0] pin_oe,  // Drive enable
	input  wire logic         hclk,    // Bus clock
	output logic      [N-1:0] pin_in   // Level seen on the pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N-1:0] float_reg;

	initial float_reg = '0;
	// No pull on these pins, so a released pin keeps changing
	always @(posedge hclk) float_reg <= ~float_reg;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & float_reg);
endmodule : pfm_pin_model

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench of the pin function multiplexer
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import pfm_pkg::*;
	logic         hclk, hresetn, hsel, hwrite, hreadyout;
	logic [31:0]  haddr, hwdata, hrdata, rd;
	logic [1:0]   htrans, hresp;
	logic [2:0]   hsize;
	logic [13:0]  pa_pin_in, pa_pin_out, pa_pin_oe, pa_gpio_out, pa_gpio_in;
	logic [55:0]  pa_fn_out, pa_fn_oe, pa_fn_in;
	logic [15:0]  pb_pin_in, pb_pin_out, pb_pin_oe, pb_gpio_out, pb_gpio_in;
	logic [63:0]  pb_fn_out, pb_fn_oe, pb_fn_in;
	logic [31:0]  idx_tab [5];
	logic [15:0]  mask_tab [5];
	logic [15:0]  shadow [5];
	int           error_cnt, check_count, cyc;

	pfm_mux u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .pa_pin_in(pa_pin_in),
		.pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
		.pa_gpio_out(pa_gpio_out), .pa_gpio_in(pa_gpio_in),
		.pa_fn_out(pa_fn_out), .pa_fn_oe(pa_fn_oe), .pa_fn_in(pa_fn_in),
		.pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out),
		.pb_pin_oe(pb_pin_oe), .pb_gpio_out(pb_gpio_out),
		.pb_gpio_in(pb_gpio_in), .pb_fn_out(pb_fn_out),
		.pb_fn_oe(pb_fn_oe), .pb_fn_in(pb_fn_in));
	pfm_pin_model #(.N(14)) u_pa (.pin_out(pa_pin_out),
		.pin_oe(pa_pin_oe), .hclk(hclk), .pin_in(pa_pin_in));
	pfm_pin_model #(.N(16)) u_pb (.pin_out(pb_pin_out),
		.pin_oe(pb_pin_oe), .hclk(hclk), .pin_in(pb_pin_in));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	task summarize;
		if (error_cnt == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task check(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			summarize();
		end
	end

	function automatic logic [31:0] ba(input logic [31:0] i);
		return {i[29:0], 2'b00};
	endfunction : ba

	task ahb(input logic w, input logic [2:0] sz, input logic [31:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task wr(input int r, input logic [15:0] v);
		ahb(1'b1, 3'h2, ba(idx_tab[r]), {16'h0000, v});
		shadow[r] = v & mask_tab[r];
	endtask : wr

	task rdchk(input int r);
		ahb(1'b0, 3'h2, ba(idx_tab[r]), 32'h00000000);
		check(rd, {16'h0000, shadow[r]});
	endtask : rdchk

	// Expected drive {out, enable} of one pin
	function automatic logic [1:0] route(input logic [1:0] c, gc,
		input logic gp, d, g, input logic [3:0] fo, fe);
		if (gp && c == gc) begin
			return {g, d};
		end
		return {fo[c], fe[c]};
	endfunction : route

	task check_pins;
		logic [29:0]  eo, ee;
		logic [119:0] ef, fm, fo, fe;
		logic [29:0]  g;
		logic [1:0]   c, r;
		int           q;
		fo = {pb_fn_out, pa_fn_out};
		fe = {pb_fn_oe, pa_fn_oe};
		g = {pb_gpio_out, pa_gpio_out};
		repeat (4) @(posedge hclk);
		#1;
		for (int p = 0; p < 30; p++) begin
			q = (p < 14) ? p : p - 14;
			c = (p < 14) ? {1'b0, shadow[0][p]} :
				(q < 8) ? shadow[4][2*q +: 2] : shadow[2][2*(q-8) +: 2];
			r = route(c, (p == 7) ? 2'b01 : 2'b00, p != 3,
				(p < 14) ? shadow[1][p] : shadow[3][q], g[p],
				fo[4*p +: 4], fe[4*p +: 4]);
			eo[p] = r[1];
			ee[p] = r[0];
			ef[4*p +: 4] = 4'h0;
			if (p == 3 || c != ((p == 7) ? 2'b01 : 2'b00)) begin
				ef[4*p + c] = r[1];
			end
			// Released peripheral pins float, so only driven or general
			fm[4*p +: 4] = (r[0] || (p != 3 &&
				c == ((p == 7) ? 2'b01 : 2'b00))) ? 4'hF : 4'h0;
		end
		check({pb_pin_oe, pa_pin_oe}, ee);
		check({pb_pin_out, pa_pin_out} & ee, eo & ee);
		check({pb_gpio_in, pa_gpio_in} & ee, eo & ee);
		check({pb_fn_in, pa_fn_in} & fm, ef & fm);
	endtask : check_pins

	////////////////////////////////////////////////////////////////////////
	initial begin
		idx_tab = '{PFM_IDX_PA_FUNC, PFM_IDX_PA_DIR, PFM_IDX_PB_FUNC,
			PFM_IDX_PB_DIR, PFM_IDX_PB_FUNC2};
		mask_tab = '{16'h3FFF, 16'h3FF7, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		shadow = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = 3'h0;
		pa_gpio_out = 14'h2A5C;
		pb_gpio_out = 16'h9A3C;
		pa_fn_out = {14{4'b0101}};
		pa_fn_oe = {14{4'b1101}};
		pb_fn_out = {16{4'b0110}};
		pb_fn_oe = '1;
		hresetn = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		check_pins();
		for (int r = 0; r < 5; r++) begin
			rdchk(r);
			wr(r, (r == 0) ? 16'h3FFF : 16'hFFFF);
			rdchk(r);
		end
		check_pins();
		// Unmapped word between the port A registers
		ahb(1'b1, 3'h2, ba(32'hFFFFFC81), 32'h0000FFFF);
		ahb(1'b0, 3'h2, ba(32'hFFFFFC81), 32'h00000000);
		check(rd, 128'h0);
		wr(3, 16'h0000);
		ahb(1'b1, PFM_SIZE_BYTE, ba(idx_tab[3]), 32'h0000005A);
		ahb(1'b1, PFM_SIZE_BYTE, ba(idx_tab[3]) + 32'h1, 32'h0000C300);
		shadow[3] = 16'hC35A;
		rdchk(3);
		wr(0, 16'h0000);
		ahb(1'b1, PFM_SIZE_BYTE, ba(idx_tab[0]) + 32'h1, 32'h00003F00);
		shadow[0] = 16'h3F00;
		rdchk(0);
		wr(0, 16'h0000);
		wr(1, 16'hFFFF);
		check_pins();
		wr(0, 16'h3FFF);
		check_pins();
		wr(1, 16'h0000);
		check_pins();
		wr(4, 16'hE4E4);
		wr(2, 16'hE4E4);
		check_pins();
		// Upper byte of port B pins 12 to 15: codes 3, 2, 1, 0
		ahb(1'b1, PFM_SIZE_BYTE, ba(idx_tab[2]) + 32'h1, 32'h00001B00);
		shadow[2] = 16'h1BE4;
		rdchk(2);
		check_pins();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int r = 0; r < 5; r++) begin
			shadow[r] = 16'h0000;
			rdchk(r);
		end
		summarize();
	end
endmodule : testbench

`default_nettype wire
